// file: serial_shadow_pkg.sv
// constants for the serial port shadow control block
package serial_shadow_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] LINE_CONTROL_ADDR = 32'h5000_1100;
   localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1104;
   localparam logic [31:0] MODEM_CONTROL_ADDR = 32'h5000_1108;
   localparam logic [31:0] PORT_STATUS_ADDR = 32'h5000_110C;
   localparam logic [31:0] SOFTWARE_RESET_CONTROL_ADDR = 32'h5000_1188;
   localparam logic [31:0] REQUEST_TO_SEND_MIRROR_ADDR = 32'h5000_118C;
   localparam logic [31:0] BREAK_CONTROL_MIRROR_ADDR = 32'h5000_1190;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SRR_PORT_RESET_BIT = 0;
   localparam int SRR_RX_FLUSH_BIT = 1;
   localparam int SRR_TX_FLUSH_BIT = 2;
   localparam int MIRROR_BIT = 0;
   localparam int FCR_ENABLE_BIT = 0;
   localparam int FCR_RX_FLUSH_BIT = 1;
   localparam int FCR_TX_FLUSH_BIT = 2;
   localparam int FCR_TRIG_LSB = 6;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_LOOPBACK_BIT = 4;
   localparam int MCR_AFC_BIT = 5;
   localparam int MCR_IR_BIT = 6;
   localparam int LCR_BREAK_BIT = 6;
   localparam int STAT_TX_LEVEL_LSB = 0;
   localparam int STAT_RX_LEVEL_LSB = 8;
   localparam int STAT_RTS_N_BIT = 16;
   localparam int STAT_SOUT_BIT = 17;
   localparam int STAT_PORT_RST_BIT = 18;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] RX_TRIG_RESET = 2'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // fifo depth and receive thresholds
   // ---------------------------------------------------------------
   localparam int LEVEL_W = 5;
   localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 5'h10;
   localparam logic [1:0] TRIG_ONE_CHAR = 2'h0;
   localparam logic [1:0] TRIG_QUARTER = 2'h1;
   localparam logic [1:0] TRIG_HALF = 2'h2;
   localparam logic [1:0] TRIG_TWO_LESS = 2'h3;
   localparam logic [LEVEL_W-1:0] THR_ONE_CHAR = 5'h01;
   localparam logic [LEVEL_W-1:0] THR_QUARTER = 5'h04;
   localparam logic [LEVEL_W-1:0] THR_HALF = 5'h08;
   localparam logic [LEVEL_W-1:0] THR_TWO_LESS = 5'h0E;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int IR_PULSE_NS = 1000;
   localparam int IR_PULSE_CYCLES = IR_PULSE_NS / CLK_PERIOD_NS;
   localparam int PORT_RST_CYCLES = 4;

endpackage

// file: fill_if.sv
// fill level carrier between the port logic and a fifo level tracker
`timescale 1ns/1ps
`default_nettype none
interface fill_if;
   logic push;
   logic pop;
   logic flush;
   logic [serial_shadow_pkg::LEVEL_W-1:0] level;
   logic empty;
   logic full;
   modport ctrl (output push, output pop, output flush, input level, input empty, input full);
   modport track (input push, input pop, input flush, output level, output empty, output full);
endinterface
`default_nettype wire

// file: fill_level_counter.sv
// fifo control portion: occupancy tracker with flush
`timescale 1ns/1ps
`default_nettype none
module fill_level_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   fill_if.track f
);
   typedef struct packed {
      logic [serial_shadow_pkg::LEVEL_W-1:0] level;
   } fill_state_t;

   fill_state_t s_reg;
   fill_state_t s_next;
   logic do_push;
   logic do_pop;

   always_comb begin
      s_next = s_reg;
      do_push = f.push && (s_reg.level != serial_shadow_pkg::FIFO_DEPTH);
      do_pop = f.pop && (s_reg.level != '0);
      if (f.flush) begin
         s_next.level = '0;
      end else if (do_push && !do_pop) begin
         s_next.level = s_reg.level + 5'h01;
      end else if (do_pop && !do_push) begin
         s_next.level = s_reg.level - 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign f.level = s_reg.level;
   assign f.empty = (s_reg.level == '0);
   assign f.full = (s_reg.level == serial_shadow_pkg::FIFO_DEPTH);
endmodule
`default_nettype wire

// file: serial_port_shadow_control.sv
// serial port shadow control registers with pin gating
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module serial_port_shadow_control (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic tx_push_i,
   input wire logic tx_pop_i,
   input wire logic rx_push_i,
   input wire logic rx_pop_i,
   input wire logic tx_serial_i,
   input wire logic ir_encoded_n_i,
   output logic tx_fifo_flush_o,
   output logic rx_fifo_flush_o,
   output logic port_soft_reset_o,
   output logic rts_n_o,
   output logic sout_o,
   output logic ir_out_n_o,
   output logic loop_cts_o,
   output logic loop_break_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic fifo_en;
      logic [1:0] rx_trig;
      logic rts_mirror_bit;
      logic loopback;
      logic afc;
      logic ir_mode;
      logic brk;
      logic tx_flush;
      logic rx_flush;
      logic [3:0] rst_cnt;
      logic port_rst;
      logic rts_n;
      logic sout;
      logic ir_out_n;
      logic loop_cts;
      logic loop_brk;
      logic [7:0] ir_div;
      logic ir_phase;
   } port_state_t;

   port_state_t s_reg;
   port_state_t s_next;

   fill_if tx_fill ();
   fill_if rx_fill ();

   logic req;
   logic wr_commit;
   logic wr_srr;
   logic [serial_shadow_pkg::LEVEL_W-1:0] rx_thr;
   logic rx_above;
   logic rts_gate;
   logic [31:0] rd_val;

   // ---------------------------------------------------------------
   // fifo level trackers
   // ---------------------------------------------------------------
   fill_level_counter tx_tracker (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .f(tx_fill.track)
   );

   fill_level_counter rx_tracker (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .f(rx_fill.track)
   );

   assign tx_fill.push = tx_push_i;
   assign tx_fill.pop = tx_pop_i;
   assign tx_fill.flush = s_reg.tx_flush | s_reg.port_rst;
   assign rx_fill.push = rx_push_i;
   assign rx_fill.pop = rx_pop_i;
   assign rx_fill.flush = s_reg.rx_flush | s_reg.port_rst;

   // ---------------------------------------------------------------
   // receive threshold and flow gate
   // ---------------------------------------------------------------
   always_comb begin
      unique case (s_reg.rx_trig)
         serial_shadow_pkg::TRIG_ONE_CHAR: rx_thr = serial_shadow_pkg::THR_ONE_CHAR;
         serial_shadow_pkg::TRIG_QUARTER: rx_thr = serial_shadow_pkg::THR_QUARTER;
         serial_shadow_pkg::TRIG_HALF: rx_thr = serial_shadow_pkg::THR_HALF;
         serial_shadow_pkg::TRIG_TWO_LESS: rx_thr = serial_shadow_pkg::THR_TWO_LESS;
      endcase
   end

   assign rx_above = (rx_fill.level >= rx_thr);
   assign rts_gate = s_reg.afc && s_reg.fifo_en && rx_above;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign req = cyc_i && stb_i;
   assign wr_commit = req && we_i && s_reg.ack && sel_i[0];
   assign wr_srr = wr_commit && (adr_i == serial_shadow_pkg::SOFTWARE_RESET_CONTROL_ADDR);

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (adr_i)
         serial_shadow_pkg::LINE_CONTROL_ADDR: begin
            rd_val[serial_shadow_pkg::LCR_BREAK_BIT] = s_reg.brk;
         end
         serial_shadow_pkg::FIFO_CONTROL_ADDR: begin
            rd_val[serial_shadow_pkg::FCR_ENABLE_BIT] = s_reg.fifo_en;
            rd_val[serial_shadow_pkg::FCR_TRIG_LSB +: 2] = s_reg.rx_trig;
         end
         serial_shadow_pkg::MODEM_CONTROL_ADDR: begin
            rd_val[serial_shadow_pkg::MCR_RTS_BIT] = s_reg.rts_mirror_bit;
            rd_val[serial_shadow_pkg::MCR_LOOPBACK_BIT] = s_reg.loopback;
            rd_val[serial_shadow_pkg::MCR_AFC_BIT] = s_reg.afc;
            rd_val[serial_shadow_pkg::MCR_IR_BIT] = s_reg.ir_mode;
         end
         serial_shadow_pkg::PORT_STATUS_ADDR: begin
            rd_val[serial_shadow_pkg::STAT_TX_LEVEL_LSB +: serial_shadow_pkg::LEVEL_W] = tx_fill.level;
            rd_val[serial_shadow_pkg::STAT_RX_LEVEL_LSB +: serial_shadow_pkg::LEVEL_W] = rx_fill.level;
            rd_val[serial_shadow_pkg::STAT_RTS_N_BIT] = s_reg.rts_n;
            rd_val[serial_shadow_pkg::STAT_SOUT_BIT] = s_reg.sout;
            rd_val[serial_shadow_pkg::STAT_PORT_RST_BIT] = s_reg.port_rst;
         end
         serial_shadow_pkg::REQUEST_TO_SEND_MIRROR_ADDR: begin
            rd_val[serial_shadow_pkg::MIRROR_BIT] = s_reg.rts_mirror_bit;
         end
         serial_shadow_pkg::BREAK_CONTROL_MIRROR_ADDR: begin
            rd_val[serial_shadow_pkg::MIRROR_BIT] = s_reg.brk;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.ack = req && !s_reg.ack;
      s_next.rdata = (req && !s_reg.ack && !we_i) ? rd_val : serial_shadow_pkg::RDATA_RESET;
      s_next.tx_flush = 1'b0;
      s_next.rx_flush = 1'b0;

      if (wr_commit) begin
         unique case (adr_i)
            serial_shadow_pkg::LINE_CONTROL_ADDR: begin
               s_next.brk = dat_i[serial_shadow_pkg::LCR_BREAK_BIT];
            end
            serial_shadow_pkg::FIFO_CONTROL_ADDR: begin
               s_next.fifo_en = dat_i[serial_shadow_pkg::FCR_ENABLE_BIT];
               s_next.rx_trig = dat_i[serial_shadow_pkg::FCR_TRIG_LSB +: 2];
               s_next.tx_flush = dat_i[serial_shadow_pkg::FCR_TX_FLUSH_BIT];
               s_next.rx_flush = dat_i[serial_shadow_pkg::FCR_RX_FLUSH_BIT];
               // disabling the fifos empties both
               if (s_reg.fifo_en && !dat_i[serial_shadow_pkg::FCR_ENABLE_BIT]) begin
                  s_next.tx_flush = 1'b1;
                  s_next.rx_flush = 1'b1;
               end
            end
            serial_shadow_pkg::MODEM_CONTROL_ADDR: begin
               s_next.rts_mirror_bit = dat_i[serial_shadow_pkg::MCR_RTS_BIT];
               s_next.loopback = dat_i[serial_shadow_pkg::MCR_LOOPBACK_BIT];
               s_next.afc = dat_i[serial_shadow_pkg::MCR_AFC_BIT];
               s_next.ir_mode = dat_i[serial_shadow_pkg::MCR_IR_BIT];
            end
            serial_shadow_pkg::SOFTWARE_RESET_CONTROL_ADDR: begin
               s_next.tx_flush = dat_i[serial_shadow_pkg::SRR_TX_FLUSH_BIT];
               s_next.rx_flush = dat_i[serial_shadow_pkg::SRR_RX_FLUSH_BIT];
            end
            serial_shadow_pkg::REQUEST_TO_SEND_MIRROR_ADDR: begin
               s_next.rts_mirror_bit = dat_i[serial_shadow_pkg::MIRROR_BIT];
            end
            serial_shadow_pkg::BREAK_CONTROL_MIRROR_ADDR: begin
               s_next.brk = dat_i[serial_shadow_pkg::MIRROR_BIT];
            end
            default: begin
               s_next.brk = s_reg.brk;
            end
         endcase
      end

      // port reset: raised on the write, released after a count on an edge
      if (wr_srr && dat_i[serial_shadow_pkg::SRR_PORT_RESET_BIT]) begin
         s_next.port_rst = 1'b1;
         s_next.rst_cnt = 4'(serial_shadow_pkg::PORT_RST_CYCLES);
      end else if (s_reg.rst_cnt != 4'h0) begin
         s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
         s_next.port_rst = (s_reg.rst_cnt != 4'h1);
      end

      // port reset clears the controller state on both sides
      if (s_reg.port_rst) begin
         s_next.fifo_en = 1'b0;
         s_next.rx_trig = serial_shadow_pkg::RX_TRIG_RESET;
         s_next.rts_mirror_bit = 1'b0;
         s_next.loopback = 1'b0;
         s_next.afc = 1'b0;
         s_next.ir_mode = 1'b0;
         s_next.brk = 1'b0;
      end

      // infrared pulse divider
      if (s_reg.ir_mode && s_reg.brk) begin
         if (s_reg.ir_div == 8'(serial_shadow_pkg::IR_PULSE_CYCLES - 1)) begin
            s_next.ir_div = 8'h00;
            s_next.ir_phase = !s_reg.ir_phase;
         end else begin
            s_next.ir_div = s_reg.ir_div + 8'h01;
         end
      end else begin
         s_next.ir_div = 8'h00;
         s_next.ir_phase = 1'b0;
      end

      // pin drive
      if (s_reg.loopback) begin
         s_next.rts_n = 1'b1;
         s_next.sout = 1'b1;
         s_next.loop_cts = s_reg.rts_mirror_bit;
         s_next.loop_brk = s_reg.brk;
      end else begin
         s_next.rts_n = !s_reg.rts_mirror_bit || rts_gate;
         s_next.sout = tx_serial_i && !s_reg.brk;
         s_next.loop_cts = 1'b0;
         s_next.loop_brk = 1'b0;
      end

      if (s_reg.ir_mode && s_reg.brk) begin
         s_next.ir_out_n = !s_reg.ir_phase;
      end else if (s_reg.ir_mode && !s_reg.loopback) begin
         s_next.ir_out_n = ir_encoded_n_i;
      end else begin
         s_next.ir_out_n = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.rts_n <= 1'b1;
         s_reg.sout <= 1'b1;
         s_reg.ir_out_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dat_o = s_reg.rdata;
   assign ack_o = s_reg.ack;
   assign tx_fifo_flush_o = s_reg.tx_flush;
   assign rx_fifo_flush_o = s_reg.rx_flush;
   assign port_soft_reset_o = s_reg.port_rst;
   assign rts_n_o = s_reg.rts_n;
   assign sout_o = s_reg.sout;
   assign ir_out_n_o = s_reg.ir_out_n;
   assign loop_cts_o = s_reg.loop_cts;
   assign loop_break_o = s_reg.loop_brk;
endmodule
`default_nettype wire

// file: serial_port_shadow_control_asserts.sv
// concurrent checks on the shadow control block ports
`timescale 1ns/1ps
`default_nettype none
module serial_port_shadow_control_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic tx_serial_i,
   input wire logic ir_encoded_n_i,
   input wire logic tx_fifo_flush_o,
   input wire logic rx_fifo_flush_o,
   input wire logic port_soft_reset_o,
   input wire logic rts_n_o,
   input wire logic sout_o,
   input wire logic ir_out_n_o,
   input wire logic loop_cts_o,
   input wire logic loop_break_o
);
   localparam logic [31:0] SRR_A = serial_shadow_pkg::SOFTWARE_RESET_CONTROL_ADDR;
   localparam logic [31:0] RTS_A = serial_shadow_pkg::REQUEST_TO_SEND_MIRROR_ADDR;
   logic rts_q, lb_q, afc_q, ir_q, brk_q, prst_q, calm, commit;
   assign commit = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   assign calm = !port_soft_reset_o && !prst_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // control bits rebuilt from committed bus writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      prst_q <= port_soft_reset_o;
      if (rst_i || port_soft_reset_o) begin
         {rts_q, lb_q, afc_q, ir_q, brk_q} <= 5'h00;
      end else if (commit) begin
         if (adr_i == serial_shadow_pkg::MODEM_CONTROL_ADDR) begin
            {ir_q, afc_q, lb_q} <= dat_i[6:4];
            rts_q <= dat_i[1];
         end
         if (adr_i == serial_shadow_pkg::REQUEST_TO_SEND_MIRROR_ADDR)
            rts_q <= dat_i[0];
         if (adr_i == serial_shadow_pkg::LINE_CONTROL_ADDR)
            brk_q <= dat_i[6];
         if (adr_i == serial_shadow_pkg::BREAK_CONTROL_MIRROR_ADDR)
            brk_q <= dat_i[0];
      end
   end
   sequence wr_at(logic [31:0] a, int b);
      commit && adr_i == a && dat_i[b];
   endsequence
   // port reset stands four cycles, then drops
   sequence rst_pulse;
      port_soft_reset_o[*4] ##1 !port_soft_reset_o;
   endsequence
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   ack_one_cycle_a: assert property (ack_o |=> !ack_o) else $error("ack held over two cycles");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h00000000) else $error("read data not zero");
   tx_flush_pulse_a: assert property (wr_at(SRR_A, 2) |-> ##[1:2] tx_fifo_flush_o)
      else $error("no transmit flush pulse");
   rx_flush_pulse_a: assert property (wr_at(SRR_A, 1) |-> ##[1:2] rx_fifo_flush_o)
      else $error("no receive flush pulse");
   port_rst_start_a: assert property (wr_at(SRR_A, 0) |-> ##[1:2] port_soft_reset_o)
      else $error("port reset not raised");
   port_rst_hold_a: assert property ($rose(port_soft_reset_o) |-> rst_pulse)
      else $error("port reset length wrong");
   rts_mirror_read_a: assert property (ack_o && !we_i && adr_i == RTS_A
      |-> dat_o == 32'(rts_q)) else $error("mirror read differs from control bit");
   rts_plain_a: assert property ($past(calm) && !$past(lb_q) && !$past(afc_q) |-> rts_n_o == !$past(rts_q))
      else $error("request-to-send pin wrong");
   loop_pins_a: assert property ($past(calm) && $past(lb_q) |-> rts_n_o && sout_o
      && loop_cts_o == $past(rts_q) && loop_break_o == $past(brk_q)) else $error("loopback pins wrong");
   break_low_a: assert property ($past(calm) && !$past(lb_q) && $past(brk_q) |-> !sout_o)
      else $error("break not driven low");
   sout_pass_a: assert property ($past(calm) && !$past(lb_q) && !$past(brk_q) |-> sout_o == $past(tx_serial_i))
      else $error("serial output not passed through");
   ir_idle_a: assert property (!$past(ir_q) |-> ir_out_n_o) else $error("infrared output active");
   ir_pass_a: assert property ($past(calm) && $past(ir_q) && !$past(brk_q) && !$past(lb_q)
      |-> ir_out_n_o == $past(ir_encoded_n_i)) else $error("infrared data not passed through");
   ir_pulse_a: assert property (ir_q && brk_q |-> ##[1:202] ($changed(ir_out_n_o) || !(ir_q && brk_q)))
      else $error("infrared output not pulsing");
endmodule
bind serial_port_shadow_control serial_port_shadow_control_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .tx_serial_i(tx_serial_i), .tx_fifo_flush_o(tx_fifo_flush_o), .rx_fifo_flush_o(rx_fifo_flush_o),
   .port_soft_reset_o(port_soft_reset_o), .rts_n_o(rts_n_o), .sout_o(sout_o), .ir_out_n_o(ir_out_n_o),
   .loop_cts_o(loop_cts_o), .loop_break_o(loop_break_o), .ir_encoded_n_i(ir_encoded_n_i));
`default_nettype wire

// file: modem_partner.sv
// modem side model: sends a character only while request-to-send is active
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic send_i,
   input wire logic rts_n_i,
   output logic rx_push_o,
   output logic [7:0] held_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_push_o <= 1'b0;
         held_o <= 8'h00;
      end else begin
         rx_push_o <= send_i && !rts_n_i;
         if (send_i && rts_n_i)
            held_o <= held_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: tb_serial_port_shadow_control.sv
// self-checking bench for the shadow control block
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_shadow_control;
   localparam logic [31:0] A_RST = serial_shadow_pkg::SOFTWARE_RESET_CONTROL_ADDR;
   localparam logic [31:0] A_RTS = serial_shadow_pkg::REQUEST_TO_SEND_MIRROR_ADDR;
   localparam logic [31:0] A_BRK = serial_shadow_pkg::BREAK_CONTROL_MIRROR_ADDR;
   localparam logic [31:0] A_LINE = serial_shadow_pkg::LINE_CONTROL_ADDR;
   localparam logic [31:0] A_FIFO = serial_shadow_pkg::FIFO_CONTROL_ADDR;
   localparam logic [31:0] A_MODEM = serial_shadow_pkg::MODEM_CONTROL_ADDR;
   localparam logic [31:0] A_STAT = serial_shadow_pkg::PORT_STATUS_ADDR;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, tx_push_i, tx_serial_i, ir_enc, send, r, b, ts;
   logic ack_o, txf, rxf, psr, rts_n, sout, ir_n, lcts, lbrk, rx_push;
   logic [31:0] adr_i, dat_i, dat_o, rdata, thr, d;
   logic [3:0] sel_i;
   logic [7:0] held;
   logic [31:0] regs [3] = '{A_RST, A_RTS, A_BRK};
   int num_errors = 0;
   int comparisons = 0;
   int txf_n = 0, rxf_n = 0, psr_n = 0, tog;
   serial_port_shadow_control uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_push_i(tx_push_i),
      .tx_pop_i(1'b0), .rx_push_i(rx_push), .rx_pop_i(1'b0), .tx_serial_i(tx_serial_i), .ir_encoded_n_i(ir_enc),
      .tx_fifo_flush_o(txf), .rx_fifo_flush_o(rxf), .port_soft_reset_o(psr), .rts_n_o(rts_n), .sout_o(sout),
      .ir_out_n_o(ir_n), .loop_cts_o(lcts), .loop_break_o(lbrk));
   modem_partner far (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .rts_n_i(rts_n), .rx_push_o(rx_push),
      .held_o(held));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      txf_n += int'(txf);
      rxf_n += int'(rxf);
      psr_n += int'(psr);
      ir_enc <= 1'($urandom);
   end
   // ---------------------------------------------------------------
   // bus, stimulus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, v, 4'hF};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      if (n >= 40)
         num_errors++;
      rdata = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_i);
   endtask
   task automatic snd();
      @(posedge clk_i);
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   function automatic logic [31:0] thr_of(input int c);
      case (c)
         0: return 32'(serial_shadow_pkg::THR_ONE_CHAR);
         1: return 32'(serial_shadow_pkg::THR_QUARTER);
         2: return 32'(serial_shadow_pkg::THR_HALF);
         default: return 32'(serial_shadow_pkg::THR_TWO_LESS);
      endcase
   endfunction
   task automatic results();
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      results();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h500A1A35));
      {rst_i, cyc_i, stb_i, we_i, tx_push_i, send, tx_serial_i} = 7'h41;
      {adr_i, dat_i, sel_i} = '0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (regs[i]) begin
         wb(1'b0, regs[i], 32'h0);
         chk("reset_read", 32'h0, rdata);
      end
      wb(1'b1, 32'h5000_1200, 32'hFFFF_FFFF);
      wb(1'b0, 32'h5000_1200, 32'h0);
      chk("unmapped", 32'h0, rdata);
      repeat (8) begin
         {r, b, ts} = 3'($urandom);
         d = $urandom;
         tx_serial_i <= ts;
         if (d[31]) begin
            wb(1'b1, A_RTS, {d[30:0], r});
            wb(1'b1, A_LINE, 32'(b) << 6);
         end else begin
            wb(1'b1, A_MODEM, 32'(r) << 1);
            wb(1'b1, A_BRK, {d[30:0], b});
         end
         wb(1'b0, A_RTS, 32'h0);
         chk("rts_mirror", 32'(r), rdata);
         wb(1'b0, A_MODEM, 32'h0);
         chk("modem_rts", 32'(r), 32'(rdata[1]));
         wb(1'b0, A_BRK, 32'h0);
         chk("break_mirror", 32'(b), rdata);
         wb(1'b0, A_LINE, 32'h0);
         chk("line_break", 32'(b), 32'(rdata[6]));
         chk("rts_pin", 32'(!r), 32'(rts_n));
         chk("sout_pin", 32'(ts & !b), 32'(sout));
      end
      wb(1'b1, A_BRK, 32'h0);
      tx_serial_i <= 1'b1;
      repeat (5) begin
         @(posedge clk_i);
         tx_push_i <= 1'b1;
         @(posedge clk_i);
         tx_push_i <= 1'b0;
      end
      wb(1'b1, A_RST, 32'h4);
      settle();
      wb(1'b0, A_STAT, 32'h0);
      chk("tx_flushed", 32'h0, 32'(rdata[4:0]));
      chk("tx_flush_pulse", 32'h1, 32'(txf_n));
      for (int c = 0; c < 4; c++) begin
         thr = thr_of(c);
         wb(1'b1, A_FIFO, 32'h1 | (32'(c) << 6));
         wb(1'b1, A_MODEM, 32'h22);
         settle();
         repeat (int'(thr) - 1) snd();
         chk("rts_below", 32'h0, 32'(rts_n));
         snd();
         chk("rts_at_threshold", 32'h1, 32'(rts_n));
         snd();
         wb(1'b0, A_STAT, 32'h0);
         chk("rx_level", thr, 32'(rdata[12:8]));
         wb(1'b1, A_RST, 32'h2);
         settle();
         wb(1'b0, A_STAT, 32'h0);
         chk("rx_flushed", 32'h0, 32'(rdata[12:8]));
      end
      chk("rx_flush_pulses", 32'h4, 32'(rxf_n));
      chk("modem_held", 32'h4, 32'(held));
      wb(1'b1, A_MODEM, 32'h12);
      wb(1'b1, A_BRK, 32'h1);
      settle();
      chk("loop_pins", 32'h3, {30'h0, rts_n, sout});
      chk("loop_back", 32'h3, {30'h0, lcts, lbrk});
      wb(1'b1, A_MODEM, 32'h40);
      tog = 0;
      b = ir_n;
      repeat (450) begin
         @(negedge clk_i);
         tog += int'(ir_n != b);
         b = ir_n;
      end
      chk("ir_pulsing", 32'h1, 32'(tog >= 2));
      wb(1'b1, A_BRK, 32'h0);
      repeat (4) settle();
      wb(1'b1, A_MODEM, 32'h02);
      wb(1'b1, A_RST, 32'h1);
      repeat (8) @(posedge clk_i);
      chk("port_rst_len", 32'h1, 32'(psr_n >= 3 && psr_n <= 4));
      wb(1'b0, A_STAT, 32'h0);
      chk("status_after_rst", 32'h0003_0000, rdata);
      wb(1'b0, A_BRK, 32'h0);
      chk("break_after_rst", 32'h0, rdata);
      results();
   end
endmodule
`default_nettype wire
